// ===== src/rci_consts.svh
// Constants for the serial command interpreter
`ifndef RCI_CONSTS_SVH
`define RCI_CONSTS_SVH
`define RCI_CLOCK_HZ 40000000
`define RCI_BAUD_RUN 38400
`define RCI_BAUD_BOOT 19200
`define RCI_DIV_RUN ((`RCI_CLOCK_HZ + `RCI_BAUD_RUN / 2) / `RCI_BAUD_RUN)
`define RCI_DIV_BOOT ((`RCI_CLOCK_HZ + `RCI_BAUD_BOOT / 2) / `RCI_BAUD_BOOT)
`define RCI_HOLD_MS 1000
`define RCI_HOLD_CYCLES ((`RCI_CLOCK_HZ / 1000) * `RCI_HOLD_MS)
`define RCI_ADDR_CTRL 4'h0
`define RCI_ADDR_STATUS 4'h1
`define RCI_ADDR_MASK 4'h2
`define RCI_ADDR_SETTINGS 4'h3
`define RCI_ADDR_CALL_LO 4'h4
`define RCI_ADDR_CALL_HI 4'h5
`define RCI_CTRL_LEGACY 0
`define RCI_CTRL_PROG_DONE 1
`define RCI_CTRL_DEFAULTS 2
`define RCI_EV_ALARM 0
`define RCI_EV_MODE 1
`define RCI_EV_HOLD 2
`define RCI_EV_CALL 3
`define RCI_EV_POLL 4
`define RCI_EV_BAD 5
`define RCI_EV_BOOT 6
`define RCI_EV_W 7
`define RCI_MODE_COUNT 4
`define RCI_CALL_LEN 6
`define RCI_REC_LEN 64
`define RCI_CH_SEMI 8'h3B
`define RCI_CH_COLON 8'h3A
`define RCI_CH_QUERY 8'h3F
`define RCI_CH_COMMA 8'h2C
`define RCI_CH_SPACE 8'h20
`define RCI_CH_ZERO 8'h30
`endif

// ===== src/rci_pkg.sv
// Types for the serial command interpreter
package rci_pkg;
   typedef struct packed {
      logic [7:0] count;
      logic [15:0][7:0] text;
   } rci_field_type;
   // Measured values arrive preformatted as ASCII text, except range as a 2-bit code
   typedef struct packed {
      logic [8*9-1:0] power;
      logic [8*5-1:0] imped;
      logic [8*5-1:0] phase;
      logic [8*5-1:0] dbm;
      logic [8*4-1:0] swr;
      logic [1:0] range;
   } rci_meas_type;
   typedef enum logic [4:0] {
      PS_IDLE = 5'b00001,
      PS_CMD = 5'b00010,
      PS_CALL = 5'b00100,
      PS_END = 5'b01000,
      PS_BOOT = 5'b10000
   } rci_parse_type;
endpackage : rci_pkg

// ===== src/rci_top.sv
// Serial command interpreter with UART, record builder and bus slave
// What this block does
// - Link runs 38400 baud, 8 data, no parity, one stop, no handshake.
// - Alarm command steps set point off,1.5,2.0,2.5,3.0 cyclically.
// - Mode command steps mode selection to the next in its list.
// - Fast/slow command toggles fast response versus peak hold.
// - Callsign command carries six characters, stored as the callsign.
// - Poll reply is one semicolon-led comma record in fixed field order.
// - Alarm field encodes off as 0 and 1.5..3.0 as 1..4.
// - Range field: high 0, middle 1, low 2.
// - Hold field is 0 for fast and 1 for peak hold.
// - Callsign field always six characters, padded with spaces.
// - Legacy mode uses 19200 baud and omits dBm and SWR fields.
// - Firmware programming uses 19200 baud on the same port.
// - Mode held one second, released, then alarm press enters bootloader.
// - During programming after software reset a reset message is shown.
// - When programming completes the device restarts by itself.
// - Programming the data area restores factory calibration defaults.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`include "rci_consts.svh"
module rci_top import rci_pkg::*; #(
   parameter int CLOCK_HZ = `RCI_CLOCK_HZ,
   parameter int HOLD_CYCLES = (CLOCK_HZ / 1000) * `RCI_HOLD_MS
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic rx_pin,
   output logic tx_pin,
   input wire logic mode_button,
   input wire logic alarm_button,
   input wire rci_meas_type meas,
   output logic [2:0] alarm_code,
   output logic [1:0] mode_sel,
   output logic peak_hold,
   output logic [47:0] callsign,
   output logic reset_message,
   output logic boot_mode,
   output logic restart_pulse,
   output logic load_defaults,
   output logic irq,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // Dividers follow the clock so a slower clock keeps the baud rates
   localparam int DIV_RUN = (CLOCK_HZ + `RCI_BAUD_RUN / 2) / `RCI_BAUD_RUN;
   localparam int DIV_BOOT = (CLOCK_HZ + `RCI_BAUD_BOOT / 2) / `RCI_BAUD_BOOT;
   // Counters are 12 bits wide and need a few clocks per half bit
   if (HOLD_CYCLES < 2 || DIV_RUN < 4 || DIV_BOOT > 4095) begin : g_bad_param
      $error("Parameters out of range for this logic");
   end

   // Bit time for the current baud rate
   function automatic logic [11:0] bit_div(input logic slow);
      bit_div = slow ? 12'(DIV_BOOT) : 12'(DIV_RUN);
   endfunction : bit_div

   // Two-stage synchronisers for the pins
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= 3'h1; // Idle levels: no false edge after reset
         sync_b <= 3'h1;
      end else begin
         sync_a <= {alarm_button, mode_button, rx_pin};
         sync_b <= sync_a;
      end
   end
   logic rx_s, mode_s, alarm_s;
   assign rx_s = sync_b[0];
   assign mode_s = sync_b[1];
   assign alarm_s = sync_b[2];

   logic legacy;
   logic slow;
   assign slow = legacy | boot_mode;

   // Receiver: start bit, 8 data, one stop, no parity
   logic [11:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh;
   logic rx_busy, rx_valid;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_cnt <= 12'h000;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_busy <= 1'b0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!rx_s) begin
               rx_busy <= 1'b1;
               rx_bit <= 4'h0;
               rx_cnt <= bit_div(slow) >> 1; // Sample mid-bit
            end
         end else if (rx_cnt != 12'h000) begin
            rx_cnt <= rx_cnt - 12'h001;
         end else begin
            rx_cnt <= bit_div(slow) - 12'h001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s) begin
               rx_busy <= 1'b0; // False start glitch
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
               rx_sh <= {rx_s, rx_sh[7:1]};
            end else if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_valid <= rx_s; // Framing error drops the byte
            end
         end
      end
   end

   // Command parser
   rci_parse_type pstate;
   logic [7:0] cmd;
   logic [2:0] call_idx;
   logic [47:0] call_buf;
   logic [`RCI_EV_W-1:0] ev;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pstate <= PS_IDLE;
         cmd <= 8'h00;
         call_idx <= 3'h0;
         call_buf <= 48'h0;
      end else if (boot_mode) begin
         pstate <= PS_BOOT; // Loader owns the port
      end else if (rx_valid) begin
         unique case (pstate)
            PS_IDLE, PS_BOOT: begin
               if (rx_sh == `RCI_CH_SEMI || rx_sh == `RCI_CH_COLON)
                  pstate <= PS_CMD;
               else
                  pstate <= PS_IDLE;
            end
            PS_CMD: begin
               cmd <= rx_sh;
               call_idx <= 3'h0;
               pstate <= (rx_sh == 8'h43) ? PS_CALL : PS_END;
            end
            PS_CALL: begin
               call_buf <= {call_buf[39:0], rx_sh};
               call_idx <= call_idx + 3'h1;
               if (call_idx == 3'(`RCI_CALL_LEN - 1))
                  pstate <= PS_END;
            end
            PS_END: pstate <= PS_IDLE;
         endcase
      end
   end

   // Command events, one cycle each
   logic ended;
   assign ended = rx_valid && pstate == PS_END && !boot_mode &&
                  rx_sh == `RCI_CH_QUERY;
   always_comb begin
      ev = '0;
      if (ended) begin
         unique case (cmd)
            8'h41: ev[`RCI_EV_ALARM] = 1'b1;
            8'h4D: ev[`RCI_EV_MODE] = 1'b1;
            8'h46: ev[`RCI_EV_HOLD] = 1'b1;
            8'h43: ev[`RCI_EV_CALL] = 1'b1;
            8'h50: ev[`RCI_EV_POLL] = 1'b1;
            default: ev[`RCI_EV_BAD] = 1'b1;
         endcase
      end else if (rx_valid && pstate == PS_END) begin
         ev[`RCI_EV_BAD] = 1'b1;
      end
   end

   // Settings
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alarm_code <= 3'h0;
         mode_sel <= 2'h0;
         peak_hold <= 1'b0;
         callsign <= {6{`RCI_CH_SPACE}};
      end else begin
         if (ev[`RCI_EV_ALARM])
            alarm_code <= (alarm_code == 3'h4) ? 3'h0 : alarm_code + 3'h1;
         if (ev[`RCI_EV_MODE])
            mode_sel <= mode_sel + 2'h1;
         if (ev[`RCI_EV_HOLD])
            peak_hold <= !peak_hold;
         if (ev[`RCI_EV_CALL])
            callsign <= call_buf;
      end
   end

   // Reply record buffer, filled on poll
   logic [7:0] rec [0:`RCI_REC_LEN-1];
   logic [6:0] rec_len;
   logic [6:0] tx_idx;
   logic tx_active;
   always_ff @(posedge clock) begin
      if (ev[`RCI_EV_POLL] && !tx_active) begin
         for (int i = 0; i < 9; i++)
            rec[1+i] <= meas.power[8*(8-i) +: 8];
         rec[0] <= `RCI_CH_SEMI;
         rec[10] <= `RCI_CH_COMMA;
         for (int i = 0; i < 5; i++) begin
            rec[11+i] <= meas.imped[8*(4-i) +: 8];
            rec[17+i] <= meas.phase[8*(4-i) +: 8];
            rec[40+i] <= meas.dbm[8*(4-i) +: 8];
         end
         rec[16] <= `RCI_CH_COMMA;
         rec[22] <= `RCI_CH_COMMA;
         rec[23] <= `RCI_CH_ZERO + {5'h0, alarm_code};
         rec[24] <= `RCI_CH_COMMA;
         for (int i = 0; i < 6; i++)
            rec[25+i] <= callsign[8*(5-i) +: 8];
         rec[31] <= `RCI_CH_COMMA;
         rec[32] <= `RCI_CH_ZERO + {6'h0, meas.range};
         rec[33] <= `RCI_CH_COMMA;
         rec[34] <= `RCI_CH_ZERO + {7'h0, peak_hold};
         rec[35] <= 8'h0D;
         rec[36] <= 8'h0D;
         rec[37] <= 8'h0D;
         rec[38] <= 8'h0D;
         rec[39] <= `RCI_CH_COMMA;
         rec[45] <= `RCI_CH_COMMA;
         for (int i = 0; i < 4; i++)
            rec[46+i] <= meas.swr[8*(3-i) +: 8];
      end
   end
   // Legacy record stops after hold field
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         rec_len <= 7'h00;
      else if (ev[`RCI_EV_POLL] && !tx_active)
         rec_len <= legacy ? 7'd35 : 7'd50;
   end

   // Transmitter walks the record: skips index 35..38 padding
   logic [11:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [9:0] tx_sh;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_active <= 1'b0;
         tx_idx <= 7'h00;
         tx_cnt <= 12'h000;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3FF;
         tx_pin <= 1'b1;
      end else if (!tx_active) begin
         tx_pin <= 1'b1;
         if (ev[`RCI_EV_POLL]) begin
            tx_active <= 1'b1;
            tx_idx <= 7'h00;
            tx_bit <= 4'hA; // Load on next step
            tx_cnt <= 12'h000;
         end
      end else if (tx_cnt != 12'h000) begin
         tx_cnt <= tx_cnt - 12'h001;
      end else if (tx_bit == 4'hA) begin
         if (tx_idx == rec_len) begin
            tx_active <= 1'b0;
         end else if (tx_idx >= 7'd35 && tx_idx <= 7'd38) begin
            tx_idx <= tx_idx + 7'h1;
         end else begin
            tx_sh <= {1'b1, rec[tx_idx[5:0]], 1'b0};
            tx_idx <= tx_idx + 7'h1;
            tx_bit <= 4'h0;
         end
      end else begin
         tx_pin <= tx_sh[0];
         tx_sh <= {1'b1, tx_sh[9:1]};
         tx_bit <= tx_bit + 4'h1;
         tx_cnt <= bit_div(slow) - 12'h001;
      end
   end

   // Button sequence into the bootloader
   logic [31:0] hold_cnt;
   logic in_setup, mode_prev, alarm_prev;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt <= 32'h0;
         in_setup <= 1'b0;
         mode_prev <= 1'b0;
         alarm_prev <= 1'b0;
      end else begin
         mode_prev <= mode_s;
         alarm_prev <= alarm_s;
         if (mode_s && hold_cnt < 32'(HOLD_CYCLES))
            hold_cnt <= hold_cnt + 32'h1;
         else if (!mode_s)
            hold_cnt <= 32'h0;
         if (!mode_s && mode_prev && hold_cnt >= 32'(HOLD_CYCLES))
            in_setup <= 1'b1;
         else if (boot_mode)
            in_setup <= 1'b0;
      end
   end
   logic boot_req;
   assign boot_req = in_setup && !mode_s && alarm_s && !alarm_prev;

   // Bootloader session
   logic prog_done_pulse, defaults_req;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         boot_mode <= 1'b0;
         reset_message <= 1'b0;
         restart_pulse <= 1'b0;
         load_defaults <= 1'b0;
      end else begin
         restart_pulse <= 1'b0;
         load_defaults <= 1'b0;
         if (boot_req && !boot_mode) begin
            boot_mode <= 1'b1;
            reset_message <= 1'b1;
         end else if (boot_mode && prog_done_pulse) begin
            boot_mode <= 1'b0;
            reset_message <= 1'b0;
            restart_pulse <= 1'b1;
            load_defaults <= defaults_req;
         end
      end
   end

   // Bus slave: one wait cycle, then answer
   logic [`RCI_EV_W-1:0] status, mask;
   logic [`RCI_EV_W-1:0] ev_all;
   logic acc_done;
   logic rd_status;
   assign ev_all = {boot_req, ev[5:0]};
   assign rd_status = avs_read && acc_done &&
                      avs_address == `RCI_ADDR_STATUS;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         acc_done <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         legacy <= 1'b0;
         defaults_req <= 1'b0;
         prog_done_pulse <= 1'b0;
         mask <= '0;
      end else begin
         prog_done_pulse <= 1'b0;
         acc_done <= (avs_read || avs_write) && !acc_done;
         avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
         if (avs_read && !acc_done) begin
            unique case (avs_address)
               `RCI_ADDR_CTRL:
                  avs_readdata <= {30'h0, defaults_req, legacy};
               `RCI_ADDR_STATUS:
                  avs_readdata <= {25'h0, status};
               `RCI_ADDR_MASK:
                  avs_readdata <= {25'h0, mask};
               `RCI_ADDR_SETTINGS:
                  avs_readdata <= {24'h0, boot_mode, peak_hold,
                                   mode_sel, 1'b0, alarm_code};
               `RCI_ADDR_CALL_LO:
                  avs_readdata <= callsign[31:0];
               `RCI_ADDR_CALL_HI:
                  avs_readdata <= {16'h0, callsign[47:32]};
               default: avs_readdata <= 32'h0;
            endcase
         end
         if (avs_write && acc_done) begin
            if (avs_address == `RCI_ADDR_CTRL) begin
               legacy <= avs_writedata[`RCI_CTRL_LEGACY];
               defaults_req <= avs_writedata[`RCI_CTRL_DEFAULTS];
               prog_done_pulse <= avs_writedata[`RCI_CTRL_PROG_DONE];
            end
            if (avs_address == `RCI_ADDR_MASK)
               mask <= avs_writedata[`RCI_EV_W-1:0];
         end
      end
   end

   // Sticky status; a new event beats the read-clear, which clears only
   // the bits that the read returned, so no event slips through
   logic [`RCI_EV_W-1:0] next_status;
   assign next_status = ev_all | (rd_status ?
      status & ~avs_readdata[`RCI_EV_W-1:0] : status);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & mask);
      end
   end
endmodule : rci_top

// ===== test/rci_checker.sv
// Port assertions for the serial command interpreter
`include "rci_consts.svh"
module rci_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic mode_button,
   input wire logic alarm_button,
   input wire logic [2:0] alarm_code,
   input wire logic [1:0] mode_sel,
   input wire logic peak_hold,
   input wire logic reset_message,
   input wire logic boot_mode,
   input wire logic restart_pulse,
   input wire logic load_defaults,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   AST_ALARM_CYCLE: assert property (
      $changed(alarm_code) |-> alarm_code == (($past(alarm_code) == 3'h4)
      ? 3'h0 : $past(alarm_code) + 3'h1))
      else $error("alarm set point left its cyclic order");
   AST_ALARM_RANGE: assert property (alarm_code <= 3'h4)
      else $error("alarm code above four");
   AST_MODE_STEP: assert property (
      $changed(mode_sel) |-> mode_sel == $past(mode_sel) + 2'h1)
      else $error("mode skipped a step");
   AST_HOLD_ALONE: assert property (
      $changed(peak_hold) |-> $stable(alarm_code) && $stable(mode_sel))
      else $error("hold toggle disturbed other settings");
   // Pins reach the decision three edges late through the synchroniser
   AST_BOOT_ENTRY: assert property (
      $rose(boot_mode) |-> !$past(mode_button, 3) && $past(alarm_button, 3))
      else $error("boot entered without release and alarm press");
   AST_BOOT_MSG: assert property (
      $rose(boot_mode) |-> ##[0:1] reset_message)
      else $error("no reset message in boot session");
   AST_RESTART: assert property (
      restart_pulse |-> $past(boot_mode) ##1 !restart_pulse)
      else $error("restart pulse outside boot or too long");
   AST_DEFAULTS: assert property (load_defaults |-> restart_pulse)
      else $error("defaults loaded without restart");
   AST_WAIT_STATE: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not after one wait state");
endmodule : rci_checker

bind rci_top rci_checker chk_u (.clock(clock), .reset_n(reset_n),
   .mode_button(mode_button), .alarm_button(alarm_button),
   .alarm_code(alarm_code), .mode_sel(mode_sel), .peak_hold(peak_hold),
   .reset_message(reset_message), .boot_mode(boot_mode),
   .restart_pulse(restart_pulse), .load_defaults(load_defaults),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest));

// ===== test/rci_host_model.sv
// Host side of the serial link: sends commands, collects replies
`include "rci_consts.svh"
module rci_host_model #(
   parameter int CLOCK_HZ = `RCI_CLOCK_HZ
) (
   input wire logic clock,
   output logic rx_pin,
   input wire logic tx_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int div = (CLOCK_HZ + `RCI_BAUD_RUN / 2) / `RCI_BAUD_RUN;
   logic [7:0] rx_q [$];
   initial rx_pin = 1'b1; // Idle mark level, no handshake lines
   // One frame: start, eight data bits LSB first, one stop, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         rx_pin <= f[i];
         repeat (div - 1) @(posedge clock);
      end
   endtask : send_byte
   // Receiver samples mid-bit so edge jitter does not matter
   initial forever begin
      logic [7:0] b;
      @(negedge tx_pin);
      repeat (div / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clock);
         b[i] = tx_pin;
      end
      rx_q.push_back(b);
      repeat (div) @(posedge clock);
   end
endmodule : rci_host_model

// ===== test/tb_top.sv
// Bench for the serial command interpreter
`include "rci_consts.svh"
module tb_top import rci_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, reset_n, rx_pin, tx_pin, mode_button, alarm_button;
   rci_meas_type meas;
   logic [2:0] alarm_code;
   logic [1:0] mode_sel;
   logic peak_hold, reset_message, boot_mode, restart_pulse;
   logic load_defaults, irq, avs_read, avs_write, avs_waitrequest;
   logic [47:0] callsign;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   int miscompares = 0;
   int check_count = 0;
   int n;
   // Sixteen clocks per run-rate bit keeps the run short
   localparam int SIM_HZ = 614400;

   rci_top #(.CLOCK_HZ(SIM_HZ), .HOLD_CYCLES(20)) dut_u (.clock(clock),
      .reset_n(reset_n),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .mode_button(mode_button),
      .alarm_button(alarm_button), .meas(meas), .alarm_code(alarm_code),
      .mode_sel(mode_sel), .peak_hold(peak_hold), .callsign(callsign),
      .reset_message(reset_message), .boot_mode(boot_mode),
      .restart_pulse(restart_pulse), .load_defaults(load_defaults),
      .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   rci_host_model #(.CLOCK_HZ(SIM_HZ)) host_u (.clock(clock),
      .rx_pin(rx_pin), .tx_pin(tx_pin));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic complete_run();
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d);
      int k;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50) begin
         miscompares++;
         complete_run();
      end
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check({16'h0, q}, {16'h0, exp});
   endtask : rd

   // Every event is unmasked, so irq marks completion of each command
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 5000) begin
         miscompares++;
         complete_run();
      end
   endtask : wait_irq

   task automatic cmd(input string s, input logic [31:0] st,
         input logic [31:0] set);
      foreach (s[i]) host_u.send_byte(s[i]);
      wait_irq();
      rd(`RCI_ADDR_STATUS, st);
      rd(`RCI_ADDR_SETTINGS, set);
      repeat (2) @(posedge clock);
      check(irq, 48'h0); // Read cleared the sticky bit
   endtask : cmd

   // Collect a reply record and compare it byte by byte
   task automatic reply(input string e);
      n = 0;
      while (host_u.rx_q.size() < e.len() && n < 20000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20000) begin
         miscompares++;
         complete_run();
      end
      repeat (400) @(posedge clock);
      check(host_u.rx_q.size(), e.len());
      foreach (e[i]) check(host_u.rx_q[i], e[i]);
      host_u.rx_q.delete();
   endtask : reply

   initial begin
      reset_n = 1'b0;
      mode_button = 1'b0;
      alarm_button = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      meas.power = "001457.00";
      meas.imped = "049.3";
      meas.phase = "005.0";
      meas.dbm = "061.6";
      meas.swr = "1.02";
      meas.range = 2'h2; // Low range
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      rd(`RCI_ADDR_SETTINGS, 32'h0);
      rd(`RCI_ADDR_CALL_LO, 32'h20202020);
      rd(`RCI_ADDR_CALL_HI, 32'h00002020);
      rd(4'hF, 32'h0);
      bus(1'b1, `RCI_ADDR_MASK, 32'h7F);
      rd(`RCI_ADDR_MASK, 32'h7F);
      cmd(":A?", 32'h01, 32'h01);
      check(alarm_code, 48'h1);
      cmd(";F?", 32'h04, 32'h41);
      cmd(";M?", 32'h02, 32'h51);
      cmd(";X?", 32'h20, 32'h51);
      cmd(";CAB1CD ?", 32'h08, 32'h51);
      check(callsign, 48'h414231434420);
      rd(`RCI_ADDR_CALL_LO, 32'h31434420);
      rd(`RCI_ADDR_CALL_HI, 32'h00004142);
      cmd(";P?", 32'h10, 32'h51);
      reply(";001457.00,049.3,005.0,1,AB1CD ,2,1,061.6,1.02");
      // Four more steps walk the set point round to off
      for (int i = 2; i <= 5; i++)
         cmd(":A?", 32'h01, 32'h50 | 32'(i % 5));
      bus(1'b1, `RCI_ADDR_CTRL, 32'h1);
      rd(`RCI_ADDR_CTRL, 32'h1);
      host_u.div = (SIM_HZ + `RCI_BAUD_BOOT / 2) / `RCI_BAUD_BOOT;
      cmd(";P?", 32'h10, 32'h50);
      reply(";001457.00,049.3,005.0,0,AB1CD ,2,1");
      // Long mode hold, release, then alarm press
      mode_button <= 1'b1;
      repeat (40) @(posedge clock);
      mode_button <= 1'b0;
      repeat (5) @(posedge clock);
      alarm_button <= 1'b1;
      repeat (10) @(posedge clock);
      alarm_button <= 1'b0;
      wait_irq();
      rd(`RCI_ADDR_STATUS, 32'h40);
      check(boot_mode, 48'h1);
      check(reset_message, 48'h1);
      bus(1'b1, `RCI_ADDR_CTRL, 32'h6);
      n = 0;
      while (boot_mode !== 1'b0 && n < 100) begin
         @(posedge clock);
         n++;
      end
      check(boot_mode, 48'h0);
      check(restart_pulse, 48'h1);
      check(load_defaults, 48'h1);
      check(reset_message, 48'h0);
      check(host_u.rx_q.size(), 48'h0);
      complete_run();
   end
endmodule : tb_top
